// ---- verilog/psram_pkg.sv ----
// constants and carrier types for the octal ddr psram transaction logic
// assumes one link of chip select, clock, eight data lines and a strobe
package psram_pkg;

  // command codes
  localparam logic [7:0] CMD_READ   = 8'hEE;
  localparam logic [7:0] CMD_WRITE  = 8'hDE;
  localparam logic [7:0] CMD_WREN   = 8'h06;
  localparam logic [7:0] CMD_WRDI   = 8'h04;
  localparam logic [7:0] CMD_RDREG  = 8'h65;
  localparam logic [7:0] CMD_WRREG  = 8'h71;

  // framing
  localparam int ADDR_BYTES      = 4;
  localparam int LATENCY_DEFAULT = 6;
  localparam int LATENCY_MULT    = 2;
  localparam int EDGES_PER_CLK   = 2;
  localparam int REG_COUNT_DEF   = 2;
  localparam int MEM_BYTES_DEF   = 1024;

  // register reset values
  localparam logic [15:0] REG0_RESET = 16'h0000;
  localparam logic [15:0] REG1_RESET = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_CMD2,
    ST_ADDR,
    ST_LAT,
    ST_RDATA,
    ST_WDATA,
    ST_SKIP
  } phase_t;

  // pin levels as seen at the device
  typedef struct packed {
    logic       cs_n;
    logic       ck;
    logic       read_write_strobe;
    logic [7:0] dq;
  } link_in_t;

  // pin drives from the device
  typedef struct packed {
    logic [7:0] dq;
    logic       dq_oe;
    logic       read_write_strobe;
    logic       read_write_strobe_oe;
  } link_out_t;

endpackage

// ---- verilog/psram_xact.sv ----
// device-side transaction logic of an octal ddr self-refresh dram
// assumes link pins are asynchronous to ref_clk and the link clock is much slower
`timescale 1ns/1ps

// How it works
// (R01) memory read returns addressed bytes after latency
// (R02) memory write stores bytes after latency
// (R03) host may float data during latency
// (R04) host issues write enable before first write
// (R05) memory write leaves write permit set
// (R06) host should disable writes when finished
// (R07) modifying transactions refused while permit clear
// (R08) write disable clears permit, blocks writes
// (R09) register read returns register after latency
// (R10) register write has no latency cycles
// (R11) zero latency writes reach registers only
// (R12) register writes ignore strobe mask
// (R13) strobe driven in address, toggles with read data
// (R14) always double latency count
// (R15) bytes read back in written order
// (R16) first byte A, second byte B
// (R17) register write clears permit at end
// (R18) reset clears write permit
// (R19) chip select frames each transaction
module psram_xact
  import psram_pkg::*;
#(
  parameter int LATENCY   = LATENCY_DEFAULT,
  parameter int REG_COUNT = REG_COUNT_DEF,
  parameter int MEM_BYTES = MEM_BYTES_DEF
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // link pins
  input  wire psram_pkg::link_in_t  link_pins,
  output      psram_pkg::link_out_t link_drive,
  // write permit state
  output      logic                write_permit_latch
);

  localparam int AW        = $clog2(MEM_BYTES);
  localparam int RIW       = (REG_COUNT > 1) ? $clog2(REG_COUNT) : 1;
  localparam int LAT_EDGES = LATENCY * LATENCY_MULT * EDGES_PER_CLK;
  localparam int LW        = $clog2(LAT_EDGES + 1);
  localparam logic [LW-1:0] LAT_LAST = LW'(LAT_EDGES - 1);
  localparam logic [1:0]    ADDR_LAST = 2'(ADDR_BYTES - 1);

  typedef struct packed {
    link_in_t                      s1;
    link_in_t                      s2;
    link_in_t                      s3;
    logic                          ck_lvl;
    logic                          cs_lvl;
    phase_t                        st;
    logic [7:0]                    cmd;
    logic [8*ADDR_BYTES-1:0]       addr;
    logic [1:0]                    abyte;
    logic [LW-1:0]                 lat_cnt;
    logic [AW-1:0]                 ptr;
    logic                          half;
    logic [7:0]                    hold;
    logic                          reg_done;
    logic                          permit;
    logic [REG_COUNT-1:0][15:0]    regs;
    link_out_t                     out;
  } state_t;

  state_t q;
  state_t n;

  logic [7:0]    mem [MEM_BYTES];
  logic          mem_we;
  logic [AW-1:0] mem_wa;
  logic [7:0]    mem_wd;

  logic ck_edge;
  logic cs_fall;
  logic cs_rise;
  logic [7:0] dq_s;
  logic [8*ADDR_BYTES-1:0] addr_full;

  function automatic logic [RIW-1:0] reg_idx(input logic [AW-1:0] a);
    reg_idx = RIW'(a >> 1);
  endfunction

  function automatic logic [7:0] reg_byte(input logic [15:0] w, input logic second);
    reg_byte = second ? w[7:0] : w[15:8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n         = q;
    mem_we    = 1'b0;
    mem_wa    = q.ptr;
    mem_wd    = 8'h00;
    n.s1      = link_pins;
    n.s2      = q.s1;
    n.s3      = q.s2;
    dq_s      = q.s3.dq;
    addr_full = {q.addr[8*ADDR_BYTES-9:0], dq_s};
    ck_edge   = (q.s2.ck == q.s3.ck) && (q.s3.ck != q.ck_lvl);
    cs_fall   = (q.s2.cs_n == q.s3.cs_n) && !q.s3.cs_n && q.cs_lvl;
    cs_rise   = (q.s2.cs_n == q.s3.cs_n) && q.s3.cs_n && !q.cs_lvl;
    if (ck_edge) begin
      n.ck_lvl = q.s3.ck;
    end
    if (q.s2.cs_n == q.s3.cs_n) begin
      n.cs_lvl = q.s3.cs_n;
    end

    if (cs_rise) begin
      // end of frame: settle permit latch, release pins
      if (q.st == ST_CMD2 || (q.st == ST_ADDR && q.abyte == 2'd0)) begin // [R05]
        if (q.cmd == CMD_WREN) begin
          n.permit = 1'b1;
        end else if (q.cmd == CMD_WRDI) begin
          n.permit = 1'b0;                                      // [R08]
        end
      end
      if (q.reg_done) begin
        n.permit = 1'b0;                                        // [R17]
      end
      n.st                       = ST_IDLE;                     // [R19]
      n.reg_done                 = 1'b0;
      n.out.dq_oe                = 1'b0;
      n.out.read_write_strobe_oe = 1'b0;
      n.out.read_write_strobe    = 1'b0;
    end else if (cs_fall && q.st == ST_IDLE) begin
      n.st                       = ST_CMD;                      // [R19]
      n.cmd                      = 8'h00;
      n.out.read_write_strobe_oe = 1'b1;                        // [R13]
      n.out.read_write_strobe    = 1'b1;                        // [R14]
    end else if (ck_edge && !q.cs_lvl) begin
      unique case (q.st)
        ST_IDLE: begin
        end
        ST_CMD: begin
          if (q.s3.ck) begin
            n.cmd = dq_s;                                       // [R19]
            n.st  = ST_CMD2;
          end
        end
        ST_CMD2: begin
          n.st    = ST_ADDR;
          n.abyte = 2'd0;
        end
        ST_ADDR: begin
          n.addr  = addr_full;
          n.abyte = q.abyte + 2'd1;
          if (q.abyte == ADDR_LAST) begin
            n.ptr     = addr_full[AW-1:0];
            n.half    = 1'b0;
            n.lat_cnt = '0;
            unique case (q.cmd)
              CMD_WRREG: begin
                n.st                       = ST_WDATA;          // [R10] [R11]
                n.out.read_write_strobe_oe = 1'b0;
              end
              CMD_WRITE: begin
                n.st                       = ST_LAT;            // [R02]
                n.out.read_write_strobe_oe = 1'b0;
              end
              CMD_READ, CMD_RDREG: begin
                n.st                    = ST_LAT;               // [R01] [R09]
                n.out.read_write_strobe = 1'b0;
              end
              default: begin
                n.st                       = ST_SKIP;
                n.out.read_write_strobe_oe = 1'b0;
              end
            endcase
          end
        end
        ST_LAT: begin
          // host may leave dq floating here
          n.lat_cnt = q.lat_cnt + LW'(1);                       // [R03] [R14]
          if (q.lat_cnt == LAT_LAST) begin
            if (q.cmd == CMD_WRITE) begin
              n.st = ST_WDATA;
            end else begin
              n.st          = ST_RDATA;
              n.out.dq_oe   = 1'b1;
              n.out.read_write_strobe = 1'b1;                   // [R13] [R16]
              n.half        = 1'b1;
              n.out.dq      = (q.cmd == CMD_READ) ? mem[q.ptr]
                              : reg_byte(q.regs[reg_idx(q.ptr)], 1'b0);
              n.ptr         = q.ptr + AW'(1);
            end
          end
        end
        ST_RDATA: begin
          n.half     = ~q.half;
          n.out.read_write_strobe = ~q.half;                    // [R13] [R16]
          if (q.cmd == CMD_READ) begin
            n.out.dq = mem[q.ptr];                              // [R01] [R15]
            n.ptr    = q.ptr + AW'(1);
          end else begin
            n.out.dq = reg_byte(q.regs[reg_idx(q.addr[AW-1:0])], q.half); // [R09]
          end
        end
        ST_WDATA: begin
          n.half = ~q.half;
          if (q.cmd == CMD_WRITE) begin
            // strobe high masks the byte
            mem_we = q.permit && !q.s3.read_write_strobe;       // [R02] [R07]
            mem_wd = dq_s;                                      // [R15] [R16]
            n.ptr  = q.ptr + AW'(1);
          end else if (!q.half) begin
            n.hold = dq_s;                                      // [R16]
          end else if (q.permit) begin
            n.regs[reg_idx(q.addr[AW-1:0])] = {q.hold, dq_s};   // [R12] [R07]
            n.reg_done = 1'b1;
          end
        end
        ST_SKIP: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q         <= '0;
      q.s1.cs_n <= 1'b1;
      q.s2.cs_n <= 1'b1;
      q.s3.cs_n <= 1'b1;
      q.cs_lvl  <= 1'b1;
      q.st      <= ST_IDLE;
      q.permit  <= 1'b0;                                        // [R18]
      q.regs    <= '0;
      q.regs[0] <= REG0_RESET;
      if (REG_COUNT > 1) begin
        q.regs[REG_COUNT-1] <= REG1_RESET;
      end
    end else begin
      q <= n;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign link_drive         = q.out;
  assign write_permit_latch = q.permit;

endmodule // psram_xact

// ---- verification/psram_xact_chk.sv ----
// pin-level assertions for the psram transaction block
// assumes ref_clk domain, rst_n synchronous active low
`timescale 1ns/1ps
module psram_xact_chk
  import psram_pkg::*;
(
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  input wire psram_pkg::link_in_t  link_pins,
  input wire psram_pkg::link_out_t link_drive,
  input wire logic                 write_permit_latch
);
  import psram_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // frame closed long enough for the drivers to let go
  sequence cs_idle;
    link_pins.cs_n [*7];
  endsequence
  sequence opened;
    $fell(link_pins.cs_n);
  endsequence
  sequence strobe_up;
    link_drive.read_write_strobe_oe && link_drive.read_write_strobe;
  endsequence
  latch_reset_a: assert property ($rose(rst_n) |-> !write_permit_latch)
    else $error("latch set after reset");
  latch_framed_a: assert property ($changed(write_permit_latch) |-> link_pins.cs_n)
    else $error("latch moved inside a frame");
  dq_release_a: assert property (cs_idle |-> !link_drive.dq_oe)
    else $error("data driven while deselected");
  strobe_release_a: assert property (cs_idle |-> !link_drive.read_write_strobe_oe)
    else $error("strobe driven while deselected");
  strobe_open_a: assert property (opened |-> ##[2:6] strobe_up)
    else $error("strobe not driven at frame start");
  dq_framed_a: assert property (link_drive.dq_oe |-> !$past(link_pins.cs_n, 8))
    else $error("data driven outside a frame");
  first_byte_a: assert property ($rose(link_drive.dq_oe) |-> link_drive.read_write_strobe)
    else $error("first read byte not strobe high");
  data_strobe_a: assert property (link_drive.dq_oe |-> link_drive.read_write_strobe_oe)
    else $error("read data without strobe");
endmodule // psram_xact_chk

bind psram_xact psram_xact_chk u_chk (
  .ref_clk            (ref_clk),
  .rst_n              (rst_n),
  .link_pins          (link_pins),
  .link_drive         (link_drive),
  .write_permit_latch (write_permit_latch)
);

// ---- verification/octal_host.sv ----
// host controller model driving the octal link
// assumes ck half period of 4 ref_clk, device drive wins the shared pins
`timescale 1ns/1ps
module octal_host
  import psram_pkg::*;
(
  // clock
  input  wire logic                 ref_clk,
  // link
  input  wire psram_pkg::link_out_t link_drive,
  output      psram_pkg::link_in_t  link_pins
);
  import psram_pkg::*;
  logic       cs_n_q = 1'b1;
  logic       ck_q   = 1'b0;
  logic       m_q    = 1'b0;
  logic [7:0] dq_q   = 8'h00;
  assign link_pins.cs_n = cs_n_q;
  assign link_pins.ck   = ck_q;
  assign link_pins.read_write_strobe =
    link_drive.read_write_strobe_oe ? link_drive.read_write_strobe : m_q;
  assign link_pins.dq   = link_drive.dq_oe ? link_drive.dq : dq_q;
  // one ck edge; r holds the device answer to the previous edge
  task automatic step(input logic [7:0] b, input logic m, input logic drv,
                      output logic [8:0] r);
    @(posedge ref_clk);
    dq_q <= drv ? b : ~dq_q;
    m_q  <= drv ? m : ~m_q;
    repeat (2) @(posedge ref_clk);
    ck_q <= ~ck_q;
    @(negedge ref_clk) r = {link_drive.read_write_strobe, link_drive.dq};
    @(posedge ref_clk);
  endtask
  task automatic frame(input logic [7:0] c, input logic [31:0] a, input int na,
                       input int lat, input logic [7:0] wd[$], input logic wm[$],
                       input int nrd, output logic [8:0] rq[$]);
    logic [8:0] r;
    rq = {};
    @(posedge ref_clk) cs_n_q <= 1'b0;
    repeat (4) @(posedge ref_clk);
    step(c, 1'b0, 1'b1, r);
    step(c, 1'b0, 1'b1, r);
    for (int i = 0; i < na; i++) step(a[31-8*i -: 8], 1'b0, 1'b1, r);
    for (int i = 0; i < lat; i++) step(8'h00, 1'b0, 1'b0, r);
    foreach (wd[i]) step(wd[i], wm[i], 1'b1, r);
    for (int i = 0; i < nrd; i++) begin
      step(8'h00, 1'b0, 1'b0, r);
      rq.push_back(r);
    end
    repeat (4) @(posedge ref_clk);
    cs_n_q <= 1'b1;
    repeat (4) @(posedge ref_clk);
    ck_q <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule // octal_host

// ---- verification/tb_top.sv ----
// self-checking bench for the psram transaction block
// assumes LATENCY 1, so 4 latency edges with double latency
`timescale 1ns/1ps
module tb_top;
  import psram_pkg::*;
  localparam int MB = MEM_BYTES_DEF;
  localparam int LE = 1 * LATENCY_MULT * EDGES_PER_CLK;
  logic       ref_clk = 1'b0;
  logic       rst_n   = 1'b0;
  link_in_t   pins;
  link_out_t  drv;
  logic       wpl;
  logic       permit_exp;
  int         err_total = 0;
  int         n_checks  = 0;
  logic [7:0] mem [MB];
  logic [15:0] regs [2];
  logic [7:0] wd[$];
  logic       wm[$];
  logic [8:0] rq[$];
  logic [31:0] a;
  int         n;
  psram_xact #(.LATENCY(1)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .link_pins(pins),
    .link_drive(drv), .write_permit_latch(wpl));
  octal_host u_host (.ref_clk(ref_clk), .link_drive(drv), .link_pins(pins));
  initial forever #12.5 ref_clk = ~ref_clk;
  function automatic logic [15:0] exp_rd(input int i, input logic [7:0] d);
    return {7'h00, ~i[0], d};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c);
    wd = {};
    wm = {};
    u_host.frame(c, 0, 0, 0, wd, wm, 0, rq);
    permit_exp = (c == CMD_WREN);
    chk(16'(wpl), 16'(permit_exp));
  endtask
  task automatic mwrite(input logic [31:0] ad, input int len, input bit msk);
    wd = {};
    wm = {};
    for (int i = 0; i < len; i++) begin
      wd.push_back(8'($urandom));
      wm.push_back(msk & 1'($urandom));
      if (permit_exp && !wm[i]) mem[(ad + i) % MB] = wd[i];
    end
    u_host.frame(CMD_WRITE, ad, ADDR_BYTES, LE, wd, wm, 0, rq);
    chk(16'(wpl), 16'(permit_exp));
  endtask
  task automatic mread(input logic [31:0] ad, input int len);
    wd = {};
    u_host.frame(CMD_READ, ad, ADDR_BYTES, LE, wd, wm, len, rq);
    foreach (rq[i]) chk(16'(rq[i]), exp_rd(i, mem[(ad + i) % MB]));
  endtask
  task automatic rwrite(input logic [31:0] ad);
    logic [15:0] w;
    w = 16'($urandom);
    wd = {w[15:8], w[7:0]};
    wm = {1'b1, 1'b1};
    u_host.frame(CMD_WRREG, ad, ADDR_BYTES, 0, wd, wm, 0, rq);
    if (permit_exp) regs[ad[1]] = w;
    permit_exp = 1'b0;
    chk(16'(wpl), 16'h0000);
  endtask
  task automatic rread(input logic [31:0] ad);
    wd = {};
    u_host.frame(CMD_RDREG, ad, ADDR_BYTES, LE, wd, wm, 4, rq);
    foreach (rq[i])
      chk(16'(rq[i]), exp_rd(i, i[0] ? regs[ad[1]][7:0] : regs[ad[1]][15:8]));
  endtask
  initial begin
    void'($urandom(42));
    regs[0] = REG0_RESET;
    regs[1] = REG1_RESET;
    permit_exp = 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(16'(wpl), 16'h0000);
    rread(2);
    cmd(CMD_WREN);
    mwrite(0, MB, 1'b0);
    for (int k = 0; k < 6; k++) begin
      a = (k == 0) ? MB - 3 : $urandom % MB;
      n = 1 + $urandom % 9;
      mwrite(a, n, 1'b1);
      mread(a, n + n % 2);
    end
    // unknown command with address and data: ignored until deselect
    wd = {8'($urandom), 8'($urandom)};
    wm = {1'b0, 1'b0};
    u_host.frame(8'h5A, a, ADDR_BYTES, 0, wd, wm, 0, rq);
    chk(16'(wpl), 16'(permit_exp));
    mread(a, 4);
    cmd(CMD_WRDI);
    mwrite(a, 4, 1'b0);
    mread(a, 4);
    rwrite(2);
    rread(2);
    cmd(CMD_WREN);
    rwrite(2);
    rread(2);
    rread(0);
    // mid-run reset with the latch set
    cmd(CMD_WREN);
    rst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    permit_exp = 1'b0;
    regs[0] = REG0_RESET;
    regs[1] = REG1_RESET;
    chk(16'(wpl), 16'(permit_exp));
    rread(2);
    tally_and_finish();
  end
  initial begin
    #1_500_000;
    err_total++;
    tally_and_finish();
  end
endmodule // tb_top
